// ### hdl/iism_defines.svh
// constants for the two-wire interrupt status and mask block
// assumes a 50 MHz peripheral clock and 16-bit register data
// ------------------------------------------------------------
// How it works
// R1: the receive-threshold flag is set while the receive fifo level is at or above the threshold.
// R2: the receive-threshold flag clears by itself once the level falls below the threshold.
// R3: enable bit 0 low flushes the receive fifo, holds it empty and clears the threshold flag at once.
// R4: a byte arriving while the fifo holds 32 entries sets the receive-overflow flag.
// R5: the overflowing byte is still acknowledged on the wire, but every byte taken while full is dropped.
// R6: after disable, overflow and underflow hold until the engines are idle, then clear with the internal enable.
// R7: a data-command read with an empty receive fifo sets the receive-underflow flag.
// R8: bits 11 to 0 of the mask register are read-write, one per source, gating the masked status.
// R9: the mask resets to one for all sources except start, stop and activity, which reset to zero.
// R10: the broadcast flag in bit 11 is set only when a general call address is taken and acknowledged.
// R11: the broadcast flag holds until the controller is disabled or bit 0 of its clear register is read.
// R12: data bytes after an acknowledged general call enter the receive fifo like any other data.
// R13: the start flag in bit 10 is set on every start or repeated start on the wire, master or slave.
// R14: the stop flag in bit 9 is set on every stop on the wire, master or slave.
// R15: each masked status bit is the raw bit anded with its mask bit, a one letting it through.
// R16: raw status shows every source unmasked; bits 15 to 12 of all three registers read zero.
// R17: one interrupt request output is the or of all masked status bits.
// ------------------------------------------------------------
`ifndef IISM_DEFINES_SVH
`define IISM_DEFINES_SVH
`define IISM_ADDR_MASKED  32'h5000132C
`define IISM_ADDR_MASK    32'h50001330
`define IISM_ADDR_RAW     32'h50001334
`define IISM_BIT_BCAST    11
`define IISM_BIT_START    10
`define IISM_BIT_STOP     9
`define IISM_BIT_FULL     2
`define IISM_BIT_OVER     1
`define IISM_BIT_UNDER    0
`define IISM_FLD_MASK     12
`define IISM_MASK_RESET   12'h8FF
`define IISM_FIFO_DEPTH   6'h20
`endif

// ### hdl/iism_pkg.sv
// types of the two-wire interrupt status and mask block
// assumes the defines header is compiled alongside
package iism_pkg;
  // register request from the peripheral bus decoder
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [15:0] wdata;
  } iism_req_t;

  // received byte from the protocol engine
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } iism_rxb_t;

  // whole state of the block
  typedef struct packed {
    logic            scl_s1;
    logic            scl_s2;
    logic            scl_d;
    logic            sda_s1;
    logic            sda_s2;
    logic            sda_d;
    logic [31:0][7:0] mem;
    logic [4:0]      wr_ptr;
    logic [4:0]      rd_ptr;
    logic [5:0]      level;
    logic            ien;
    logic            bcast;
    logic            start;
    logic            stop;
    logic            full;
    logic            over;
    logic            under;
    logic [11:0]     mask;
    logic [15:0]     rdata;
    logic [7:0]      rx_data;
    logic            irq;
  } iism_state_t;
endpackage

// ### hdl/iism_core.sv
// receive flags, start and stop detection, raw and masked status, mask
// assumes scl and sda come straight from pins; all other inputs share clk
`timescale 1ns/100ps
`default_nettype none
`include "iism_defines.svh"

module iism_core
  import iism_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // register access
  input  wire iism_req_t   reg_req,
  output logic [15:0]      reg_rdata,
  // wire pins, already resolved
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  // protocol engine and control
  input  wire iism_rxb_t   rx_byte,
  input  wire logic        broadcast_addr_flag_ack,
  input  wire logic        enable_bit0,
  input  wire logic        sm_idle,
  input  wire logic [5:0]  rx_threshold_level,
  input  wire logic [5:0]  tx_side_raw,
  input  wire logic        data_command_rd,
  input  wire logic        broadcast_flag_clear_rd,
  // results
  output logic [7:0]       rx_data,
  output logic             internal_enable,
  output logic             irq_req
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] raw_of(input iism_state_t s,
                                         input logic [5:0] tx);
    raw_of = {4'h0, s.bcast, s.start, s.stop, tx, s.full, s.over,
              s.under}; // see R16
  endfunction

  function automatic logic [15:0] gate(input logic [15:0] raw,
                                       input logic [11:0] m);
    gate = {4'h0, raw[11:0] & m}; // see R15
  endfunction

  iism_state_t st_reg;
  iism_state_t st_next;
  logic        push;
  logic        pop;
  logic        start_cond;
  logic        stop_cond;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // pins pass two flops before anything looks at them
    st_next.scl_s1 = scl_in;
    st_next.scl_s2 = st_reg.scl_s1;
    st_next.sda_s1 = sda_in;
    st_next.sda_s2 = st_reg.sda_s1;
    st_next.scl_d  = st_reg.scl_s2;
    st_next.sda_d  = st_reg.sda_s2;
    start_cond = st_reg.scl_s2 && st_reg.scl_d && st_reg.sda_d
                 && !st_reg.sda_s2;
    stop_cond  = st_reg.scl_s2 && st_reg.scl_d && !st_reg.sda_d
                 && st_reg.sda_s2;

    st_next.ien = enable_bit0 || (st_reg.ien && !sm_idle); // see R6

    // general call data is not special here: its bytes are queued like any other byte
    push = rx_byte.valid && enable_bit0
           && (st_reg.level != `IISM_FIFO_DEPTH); // see R5, R12
    pop  = data_command_rd && (st_reg.level != 6'h00);
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = rx_byte.data;
      st_next.wr_ptr = st_reg.wr_ptr + 5'h01;
    end
    if (pop) begin
      st_next.rx_data = st_reg.mem[st_reg.rd_ptr];
      st_next.rd_ptr = st_reg.rd_ptr + 5'h01;
    end
    st_next.level = st_reg.level + {5'h00, push} - {5'h00, pop};
    if (!enable_bit0) begin
      st_next.wr_ptr = 5'h00; // see R3
      st_next.rd_ptr = 5'h00;
      st_next.level  = 6'h00;
    end
    st_next.full = enable_bit0
                   && (st_next.level >= rx_threshold_level); // see R1, R2, R3

    // clears first, sets after, so an event in the clear cycle wins
    if (!st_next.ien) begin
      st_next.over  = 1'b0; // see R6
      st_next.under = 1'b0;
      st_next.bcast = 1'b0; // see R11
      st_next.start = 1'b0;
      st_next.stop  = 1'b0;
    end
    if (broadcast_flag_clear_rd) begin
      st_next.bcast = 1'b0; // see R11
    end
    if (rx_byte.valid && enable_bit0
        && st_reg.level == `IISM_FIFO_DEPTH) begin
      st_next.over = 1'b1; // see R4
    end
    if (data_command_rd && st_reg.ien && st_reg.level == 6'h00) begin
      st_next.under = 1'b1; // see R7
    end
    if (broadcast_addr_flag_ack) begin
      st_next.bcast = 1'b1; // see R10
    end
    if (start_cond) begin
      st_next.start = 1'b1; // see R13
    end
    if (stop_cond) begin
      st_next.stop = 1'b1; // see R14
    end

    // register port: reads answer one cycle later, unmapped reads zero
    if (reg_req.wr && reg_req.addr == `IISM_ADDR_MASK) begin
      st_next.mask = reg_req.wdata[`IISM_FLD_MASK-1:0]; // see R8
    end
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `IISM_ADDR_MASKED:
          st_next.rdata = gate(raw_of(st_reg, tx_side_raw), st_reg.mask);
        `IISM_ADDR_MASK:
          st_next.rdata = {4'h0, st_reg.mask}; // see R16
        `IISM_ADDR_RAW:
          st_next.rdata = raw_of(st_reg, tx_side_raw);
        default:
          st_next.rdata = 16'h0000;
      endcase
    end
    st_next.irq = |gate(raw_of(st_next, tx_side_raw),
                        st_next.mask); // see R17
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg      <= '0;
      st_reg.mask <= `IISM_MASK_RESET; // see R9
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata       = st_reg.rdata;
  assign rx_data         = st_reg.rx_data;
  assign internal_enable = st_reg.ien;
  assign irq_req         = st_reg.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_full_byte;
    rx_byte.valid && enable_bit0 && st_reg.level == 6'h20;
  endsequence
  sequence s_start_edge;
    st_reg.scl_s2 && st_reg.scl_d && st_reg.sda_d && !st_reg.sda_s2;
  endsequence
  sequence s_stop_edge;
    st_reg.scl_s2 && st_reg.scl_d && !st_reg.sda_d && st_reg.sda_s2;
  endsequence

  property p_full_set;
    @(posedge clk) disable iff (sys_rst)
      enable_bit0 && st_next.level >= rx_threshold_level |=> st_reg.full;
  endproperty
  a_full_set: assert property (p_full_set) // see R1
    else $error("threshold flag missing");
  property p_full_clr;
    @(posedge clk) disable iff (sys_rst)
      st_next.level < rx_threshold_level |=> !st_reg.full;
  endproperty
  a_full_clr: assert property (p_full_clr) // see R2
    else $error("threshold flag stuck");
  property p_disable_flush;
    @(posedge clk) disable iff (sys_rst)
      !enable_bit0 |=> st_reg.level == 6'h00 && !st_reg.full;
  endproperty
  a_disable_flush: assert property (p_disable_flush) // see R3
    else $error("fifo not flushed on disable");
  property p_over_set;
    @(posedge clk) disable iff (sys_rst)
      s_full_byte |=> st_reg.over;
  endproperty
  a_over_set: assert property (p_over_set) // see R4
    else $error("overflow flag missing");
  property p_over_drop;
    @(posedge clk) disable iff (sys_rst)
      s_full_byte ##0 !data_command_rd |=>
        st_reg.level == 6'h20 && $stable(st_reg.wr_ptr);
  endproperty
  a_over_drop: assert property (p_over_drop) // see R5
    else $error("byte stored while full");
  property p_idle_clear;
    @(posedge clk) disable iff (sys_rst)
      !st_reg.ien |-> !st_reg.over && !st_reg.under;
  endproperty
  a_idle_clear: assert property (p_idle_clear) // see R6
    else $error("overflow or underflow kept after idle");
  property p_under_set;
    @(posedge clk) disable iff (sys_rst)
      data_command_rd && st_reg.ien && st_reg.level == 6'h00
        |=> st_reg.under;
  endproperty
  a_under_set: assert property (p_under_set) // see R7
    else $error("underflow flag missing");
  property p_bcast_hold;
    @(posedge clk) disable iff (sys_rst)
      st_reg.bcast && st_next.ien && !broadcast_flag_clear_rd
        |=> st_reg.bcast;
  endproperty
  a_bcast_hold: assert property (p_bcast_hold) // see R11
    else $error("broadcast flag lost");
  property p_start_flag;
    @(posedge clk) disable iff (sys_rst)
      s_start_edge |=> st_reg.start;
  endproperty
  a_start_flag: assert property (p_start_flag) // see R13
    else $error("start not flagged");
  property p_stop_flag;
    @(posedge clk) disable iff (sys_rst)
      s_stop_edge |=> st_reg.stop;
  endproperty
  a_stop_flag: assert property (p_stop_flag) // see R14
    else $error("stop not flagged");
  property p_irq_or;
    @(posedge clk) disable iff (sys_rst)
      irq_req == |({st_reg.bcast, st_reg.start, st_reg.stop,
                   $past(tx_side_raw),
                   st_reg.full, st_reg.over, st_reg.under}
                   & st_reg.mask);
  endproperty
  a_irq_or: assert property (p_irq_or) // see R17
    else $error("interrupt request does not match masked status");
  property p_mask_write;
    @(posedge clk) disable iff (sys_rst)
      reg_req.wr && reg_req.addr == 32'h50001330
        |=> st_reg.mask == $past(reg_req.wdata[11:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) // see R8
    else $error("mask write not taken");

endmodule
`default_nettype wire

// ### bench/iism_wire_model.sv
// two-wire partner that makes start, repeated start and stop on the wire
// assumes pull-ups: both lines rest high and the clock stands outside frames
`timescale 1ns/100ps
`default_nettype none
module iism_wire_model (
  // resolved wire levels
  output logic scl,
  output logic sda
);
  // half of the 160 ns link clock
  localparam time HALF = 80;

  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // also a repeated start: data is released while the clock is still low
  task automatic start_cond();
    sda = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda = 1'b0;
    #HALF scl = 1'b0;
  endtask

  task automatic stop_cond();
    sda = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### bench/iism_core_tb.sv
// bench for the two-wire interrupt status and mask block
// assumes design, package, defines header and wire model compiled first
`timescale 1ns/100ps
`default_nettype none
`include "iism_defines.svh"
module iism_core_tb
  import iism_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  iism_req_t   req;
  iism_rxb_t   rxb;
  logic        gca, en, idle, dcr, bcr, irq, ien, scl, sda, rd_d, pop_d;
  logic [5:0]  thr, txr, f;
  logic [15:0] rdata, msk;
  logic [7:0]  rxd, b;
  logic [15:0] exp_q[$];
  logic [7:0]  byte_q[$];
  int          fail_count, n_checks, cyc;

  always #10 clk = ~clk;

  iism_core i_iism_core (.clk(clk), .sys_rst(sys_rst), .reg_req(req),
    .reg_rdata(rdata), .scl_in(scl), .sda_in(sda), .rx_byte(rxb),
    .broadcast_addr_flag_ack(gca), .enable_bit0(en), .sm_idle(idle),
    .rx_threshold_level(thr), .tx_side_raw(txr), .data_command_rd(dcr),
    .broadcast_flag_clear_rd(bcr), .rx_data(rxd), .internal_enable(ien),
    .irq_req(irq));
  iism_wire_model i_iism_wire_model (.scl(scl), .sda(sda));

  // ------------------------------------------------------------
  // compare and drive tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // a read carries its expectation to the monitor through the queue
  task automatic acc(input logic w, input logic [31:0] a,
                     input logic [15:0] d);
    @(posedge clk);
    req <= '{rd: ~w, wr: w, addr: a, wdata: d};
    if (!w)
      exp_q.push_back(d);
    @(posedge clk);
    req <= '0;
  endtask

  // s = {clear read, pop, general call, byte}
  task automatic stb(input logic [3:0] s, input logic [7:0] d);
    @(posedge clk);
    rxb <= '{valid: s[0], data: d};
    gca <= s[1];
    dcr <= s[2];
    bcr <= s[3];
    @(posedge clk);
    rxb <= '0;
    gca <= 1'b0;
    dcr <= 1'b0;
    bcr <= 1'b0;
  endtask

  task automatic push(input logic keep);
    b = 8'($urandom);
    if (keep)
      byte_q.push_back(b);
    stb(4'h1, b);
  endtask

  // the popped byte is compared by the monitor, one cycle after the strobe
  task automatic pop();
    stb(4'h4, 8'h00);
  endtask

  function automatic logic [15:0] raw();
    return {4'h0, f[5:3], txr, f[2:0]};
  endfunction

  task automatic look();
    acc(1'b0, `IISM_ADDR_RAW, raw());
    acc(1'b0, `IISM_ADDR_MASKED, raw() & msk);
    // a registered level is looked at away from the edge that launches it
    @(negedge clk);
    chk1(irq, |(raw() & msk));
  endtask

  // ------------------------------------------------------------
  // monitor and timeout
  // ------------------------------------------------------------
  always @(posedge clk) begin
    rd_d <= req.rd;
    pop_d <= dcr;
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      complete_run();
    end
  end

  always @(negedge clk) begin
    if (rd_d === 1'b1 && exp_q.size() > 0)
      chk(rdata, exp_q.pop_front());
    if (pop_d === 1'b1 && byte_q.size() > 0)
      chk({8'h00, rxd}, {8'h00, byte_q.pop_front()});
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h5D030A5F));
    req = '0;
    rxb = '0;
    {gca, dcr, bcr} = 3'b000;
    en = 1'b1;
    idle = 1'b1;
    thr = 6'h02;
    txr = 6'h00;
    f = 6'h00;
    msk = 16'h08FF;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    acc(1'b0, `IISM_ADDR_MASK, 16'h08FF);
    look();
    acc(1'b1, `IISM_ADDR_MASK, 16'hFFFF);
    msk = 16'h0FFF;
    acc(1'b0, `IISM_ADDR_MASK, msk);
    acc(1'b0, 32'h50001338, 16'h0000);
    txr <= 6'($urandom);
    push(1'b1);
    push(1'b1);
    f[2] = 1'b1;
    look();
    pop();
    f[2] = 1'b0;
    look();
    pop();
    repeat (32) push(1'b1);
    // the byte past a full fifo is accepted on the wire but never stored
    push(1'b0);
    f[2:1] = 2'b11;
    look();
    repeat (32) pop();
    f[2] = 1'b0;
    stb(4'h4, 8'h00);
    f[0] = 1'b1;
    look();
    acc(1'b1, `IISM_ADDR_MASK, 16'h0000);
    msk = 16'h0000;
    look();
    acc(1'b1, `IISM_ADDR_MASK, 16'h0FFF);
    msk = 16'h0FFF;
    stb(4'h2, 8'h00);
    f[5] = 1'b1;
    look();
    stb(4'h8, 8'h00);
    f[5] = 1'b0;
    look();
    stb(4'h2, 8'h00);
    f[5] = 1'b1;
    push(1'b1);
    pop();
    i_iism_wire_model.start_cond();
    repeat (8) @(posedge clk);
    f[4] = 1'b1;
    look();
    i_iism_wire_model.stop_cond();
    repeat (8) @(posedge clk);
    f[3] = 1'b1;
    look();
    push(1'b0);
    push(1'b0);
    f[2] = 1'b1;
    idle <= 1'b0;
    en <= 1'b0;
    repeat (4) @(posedge clk);
    f[2] = 1'b0;
    look();
    chk1(ien, 1'b1);
    idle <= 1'b1;
    repeat (4) @(posedge clk);
    f = 6'h00;
    look();
    chk1(ien, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
